/* xbi_fifo.sv */
// request buffer between the core and the bus sequencer
// assumes one clock; valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module xbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // full and empty from the occupancy count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* xbi_mem_model.sv */
// byte memory and serial I/O logic on the far side
// assumes the bench's clock; slow makes ready drop
`timescale 1ns/1ns
`default_nettype none
module xbi_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [13:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        sel_n,
  input  wire logic        wr_n,
  input  wire logic        rd_dir,
  input  wire logic        strobe,
  output logic      [7:0]  rdata,
  output logic             ready,
  output logic             bit_in,
  output logic             sbit
);
  logic [7:0] mem [0:16383];
  logic [7:0] last = 8'h00;
  logic [2:0] cnt  = 3'h0;
  // read data only while selected for reading, else the inverse of last
  assign rdata  = (rd_dir && !sel_n) ? mem[addr] : ~last;
  assign ready  = !slow || cnt[2];
  assign bit_in = addr[1]; // input bit mirrors address line 12
  // store writes, capture serial bits
  always @(posedge clk)
  begin
    cnt  <= cnt + 3'h1;
    last <= rdata;
    if (!sel_n && !wr_n)
      mem[addr] <= wdata;
    if (strobe)
      sbit <= addr[0];
  end
endmodule
`default_nettype wire

/* xbi_pkg.sv */
// constants and carrier types for the external bus interface
// assumes a single 100 MHz system clock and an internal core requester
// What this block does
// - 14-bit address, line 0 most significant
// - grant floats address, data, strobes, direction
// - serial output on lowest address line, strobe
// - external instruction bit on lowest line
// - 8-bit two-way data bus, MSB first
// - four phases derived from oscillator input
// - inverted phase-3 reference output
// - read direction high while memory returns data
// - memory select low only for memory address
// - write strobe low with valid write data
// - serial input sampled for bit-input instructions
// - request low gives grant after cycle
// - ready low inserts wait states
// - fetch indicator high during instruction fetch cycles
// - interrupt code synchronised internally
// - two byte cycles, lowest line 0 then 1
// - data stays input one cycle after read
// - extra cycle re-presents bit address after grant
package xbi_pkg;
  localparam int ADDR_W   = 14;
  localparam int DATA_W   = 8;
  localparam int WORD_W   = 16;
  localparam int PHASES   = 4;
  localparam int IC_W     = 3;
  localparam logic [1:0] PH3 = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  // request kinds from the core
  typedef enum logic [2:0] {
    XBI_K_READ  = 3'h0,
    XBI_K_WRITE = 3'h1,
    XBI_K_FETCH = 3'h2,
    XBI_K_BITO  = 3'h3,
    XBI_K_BITI  = 3'h4,
    XBI_K_EXTI  = 3'h5
  } xbi_kind_t;

  // one request word of the core
  typedef struct packed {
    xbi_kind_t           kind;
    logic [ADDR_W-2:0]   addr;  // upper 13 lines; lowest line set per cycle
    logic [WORD_W-1:0]   wdata; // or serial bit in bit 0
  } xbi_req_t;

  localparam int REQ_W = $bits(xbi_req_t);

  typedef enum logic [2:0] {
    XBI_S_IDLE  = 3'h0,
    XBI_S_MEM   = 3'h1,
    XBI_S_TURN  = 3'h2,
    XBI_S_BIT   = 3'h3,
    XBI_S_HOLD  = 3'h4,
    XBI_S_REBIT = 3'h5
  } xbi_state_t;
endpackage

/* xbi_top.sv */
// external bus sequencer: memory byte cycles, serial bit I/O, hold/grant
// assumes SYS_CLK stands for the oscillator input; pins are resynchronised
`timescale 1ns/1ns
`default_nettype none
module xbi_top
  import xbi_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire logic [REQ_W-1:0]  REQ_DATA,
  output logic                   RSP_VALID,
  output logic      [WORD_W-1:0] RSP_DATA,
  output logic      [ADDR_W-1:0] ADDR_OUT,
  output logic                   ADDR_OE_N,
  output logic      [DATA_W-1:0] DATA_OUT,
  input  wire logic [DATA_W-1:0] DATA_IN,
  output logic                   DATA_OE_N,
  output logic                   MEMORY_SELECT_N,
  output logic                   WRITE_N,
  output logic                   READ_DIRECTION,
  output logic                   CTRL_OE_N,
  output logic                   BITIO_STROBE,
  input  wire logic              BITIO_IN,
  input  wire logic              BUS_REQUEST_N,
  output logic                   BUS_GRANT,
  input  wire logic              READY,
  output logic                   FETCH_INDICATOR,
  output logic                   PHASE3_REF_N,
  input  wire logic [IC_W-1:0]   INT_CODE,
  output logic      [IC_W-1:0]   INT_CODE_SYNC
);
  // phase counter: one phase per input period
  logic [1:0] phase;
  wire        cyc_end = (phase == PH_LAST);

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      phase <= '0;
    else
      phase <= phase + 2'h1;
  end

  // inverted phase-3 reference
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      PHASE3_REF_N <= 1'b1;
    else
      PHASE3_REF_N <= !(phase + 2'h1 == PH3);
  end

  // three-stage synchronisers for pin inputs
  localparam int SN = IC_W + 3;
  logic [SN-1:0] s1;
  logic [SN-1:0] s2;
  logic [SN-1:0] s3;
  logic [SN-1:0] sv;
  wire  [SN-1:0] raw = {INT_CODE, BITIO_IN, BUS_REQUEST_N, READY};

  generate
    for (genvar i = 0; i < SN; i++)
    begin : g_sync
      always_ff @(posedge SYS_CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          s1[i] <= 1'b1;
          s2[i] <= 1'b1;
          s3[i] <= 1'b1;
          sv[i] <= 1'b1;
        end
        else
        begin
          s1[i] <= raw[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i])
            sv[i] <= s3[i];
        end
      end
    end
  endgenerate

  wire ready_s  = sv[0];
  wire hold_req = !sv[1];
  wire bitin_s  = sv[2];
  assign INT_CODE_SYNC = sv[SN-1:3];

  // request buffer
  logic     q_valid;
  logic     q_ready;
  xbi_req_t q_req;
  logic [REQ_W-1:0] q_raw;
  assign q_req = xbi_req_t'(q_raw);

  xbi_fifo #(.WIDTH(REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   (REQ_DATA),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_raw)
  );

  // sequencer state
  xbi_state_t state;
  xbi_state_t next_state;
  xbi_req_t   cur;
  logic       byte_sel;   // lowest address line during memory
  logic       turn_read;  // last cycle was a read
  logic       bit_pend;   // bit transfer interrupted by grant

  wire is_mem  = (cur.kind == XBI_K_READ) || (cur.kind == XBI_K_WRITE)
               || (cur.kind == XBI_K_FETCH);
  wire is_rd   = (cur.kind != XBI_K_WRITE);
  wire q_mem   = (q_req.kind == XBI_K_READ) || (q_req.kind == XBI_K_WRITE)
               || (q_req.kind == XBI_K_FETCH);
  wire mem_act = (state == XBI_S_MEM);
  wire bit_act = (state == XBI_S_BIT);
  wire wait_st = mem_act && !ready_s;
  wire mem_end = mem_act && cyc_end && ready_s && byte_sel;
  wire bit_end = bit_act && cyc_end;
  wire start   = (state == XBI_S_IDLE) && cyc_end && q_valid && !hold_req;

  assign q_ready = start;

  // next-state decode
  always_comb
  begin
    next_state = state;
    case (state)
      XBI_S_IDLE:
        if (cyc_end && hold_req)
          next_state = XBI_S_HOLD;
        else if (start)
          next_state = q_mem ? XBI_S_MEM
                     : (q_req.kind == XBI_K_BITI) ? XBI_S_REBIT // address settles first
                     : XBI_S_BIT;
      XBI_S_MEM:
        if (mem_end)
          next_state = is_rd ? XBI_S_TURN : XBI_S_IDLE;
      XBI_S_TURN:
        if (cyc_end)
          next_state = XBI_S_IDLE;
      XBI_S_BIT:
        if (cyc_end && hold_req)
          next_state = XBI_S_HOLD;
        else if (bit_end)
          next_state = XBI_S_IDLE;
      XBI_S_HOLD:
        if (cyc_end && !hold_req)
          next_state = bit_pend ? XBI_S_REBIT : XBI_S_IDLE;
      XBI_S_REBIT:
        if (cyc_end)
          next_state = XBI_S_BIT;
      default:
        next_state = XBI_S_IDLE;
    endcase
  end

  // state, request capture and byte select
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state     <= XBI_S_IDLE;
      cur       <= '0;
      byte_sel  <= 1'b0;
      bit_pend  <= 1'b0;
      turn_read <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (start)
        cur <= q_req;
      if (start)
        byte_sel <= 1'b0;
      else if (mem_act && cyc_end && !wait_st)
        byte_sel <= !byte_sel;
      if (bit_act && cyc_end && hold_req)
        bit_pend <= 1'b1;
      else if (state == XBI_S_REBIT)
        bit_pend <= 1'b0;
      turn_read <= mem_end && is_rd;
    end
  end

  // read data capture and serial input sample
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RSP_DATA  <= '0;
      RSP_VALID <= 1'b0;
    end
    else
    begin
      RSP_VALID <= (mem_end && is_rd)
                 || (bit_end && !hold_req && cur.kind == XBI_K_BITI);
      if (mem_act && cyc_end && ready_s && is_rd)
      begin
        if (byte_sel)
          RSP_DATA[DATA_W-1:0] <= DATA_IN;
        else
          RSP_DATA[WORD_W-1:DATA_W] <= DATA_IN;
      end
      if (bit_end && cur.kind == XBI_K_BITI)
        RSP_DATA <= {{(WORD_W-1){1'b0}}, bitin_s};
    end
  end

  // pin drive, registered
  wire bit_show = bit_act || (state == XBI_S_REBIT);
  wire lowline  = mem_act ? byte_sel : cur.wdata[0];
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ADDR_OUT        <= '0;
      DATA_OUT        <= '0;
      MEMORY_SELECT_N <= 1'b1;
      WRITE_N         <= 1'b1;
      READ_DIRECTION  <= 1'b0;
      BITIO_STROBE    <= 1'b0;
      BUS_GRANT       <= 1'b0;
      FETCH_INDICATOR <= 1'b0;
    end
    else
    begin
      ADDR_OUT        <= {cur.addr, lowline};
      DATA_OUT        <= byte_sel ? cur.wdata[DATA_W-1:0]
                                  : cur.wdata[WORD_W-1:DATA_W];
      MEMORY_SELECT_N <= !(mem_act && is_mem);
      WRITE_N         <= !(mem_act && cur.kind == XBI_K_WRITE);
      READ_DIRECTION  <= mem_act && is_rd;
      BITIO_STROBE    <= bit_act && (phase == PH3)
                       && (cur.kind != XBI_K_BITI);
      BUS_GRANT       <= (state == XBI_S_HOLD);
      FETCH_INDICATOR <= mem_act && cur.kind == XBI_K_FETCH;
    end
  end

  // output enables, low while driving
  assign ADDR_OE_N = BUS_GRANT || !(mem_act || bit_show || state == XBI_S_IDLE
                   || state == XBI_S_TURN);
  assign CTRL_OE_N = BUS_GRANT;
  // drive data exactly while the registered write strobe is low
  assign DATA_OE_N = BUS_GRANT || WRITE_N || turn_read;
endmodule
`default_nettype wire

/* xbi_top_properties.sv */
// checker for the external bus sequencer pins
// assumes one clock, bound onto xbi_top
`timescale 1ns/1ns
`default_nettype none
module xbi_top_properties
  import xbi_pkg::*;
(
  input wire logic              SYS_CLK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] ADDR_OUT,
  input wire logic              ADDR_OE_N,
  input wire logic              DATA_OE_N,
  input wire logic              MEMORY_SELECT_N,
  input wire logic              WRITE_N,
  input wire logic              READ_DIRECTION,
  input wire logic              CTRL_OE_N,
  input wire logic              BITIO_STROBE,
  input wire logic              BUS_REQUEST_N,
  input wire logic              BUS_GRANT,
  input wire logic              FETCH_INDICATOR,
  input wire logic              PHASE3_REF_N
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  // pin relations of the bus cycles
  AST_GRANT_FLOAT: assert property (BUS_GRANT |-> ADDR_OE_N && DATA_OE_N && CTRL_OE_N)
    else $error("outputs driven while granted");
  AST_READ_DIR: assert property (READ_DIRECTION |-> !MEMORY_SELECT_N && DATA_OE_N)
    else $error("read direction outside memory read");
  AST_WRITE: assert property (!WRITE_N |-> !MEMORY_SELECT_N && !DATA_OE_N)
    else $error("write strobe without data");
  AST_PHASE: assert property ($fell(PHASE3_REF_N) |=> PHASE3_REF_N[*3] ##1 !PHASE3_REF_N)
    else $error("reference not one low in four");
  AST_STROBE: assert property (BITIO_STROBE |-> MEMORY_SELECT_N)
    else $error("serial strobe during memory cycle");
  AST_FETCH: assert property (FETCH_INDICATOR |-> !MEMORY_SELECT_N)
    else $error("fetch flag outside memory cycle");
  AST_TURN: assert property ($fell(READ_DIRECTION) |-> DATA_OE_N[*4])
    else $error("data driven right after read");
  AST_LAST_BYTE: assert property ($rose(MEMORY_SELECT_N) |-> $past(ADDR_OUT[0]))
    else $error("memory operation not ended on second byte");
  AST_GRANT_REQ: assert property ($rose(BUS_GRANT) |->
    $past(MEMORY_SELECT_N) && !$past(BUS_REQUEST_N, 3))
    else $error("grant without request or mid cycle");
endmodule

bind xbi_top xbi_top_properties chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .ADDR_OUT(ADDR_OUT), .ADDR_OE_N(ADDR_OE_N), .DATA_OE_N(DATA_OE_N),
  .MEMORY_SELECT_N(MEMORY_SELECT_N), .WRITE_N(WRITE_N),
  .READ_DIRECTION(READ_DIRECTION), .CTRL_OE_N(CTRL_OE_N),
  .BITIO_STROBE(BITIO_STROBE), .BUS_REQUEST_N(BUS_REQUEST_N),
  .BUS_GRANT(BUS_GRANT), .FETCH_INDICATOR(FETCH_INDICATOR),
  .PHASE3_REF_N(PHASE3_REF_N));
`default_nettype wire

/* xbi_top_tb.sv */
// self-checking bench for xbi_top
// assumes xbi_mem_model on the pins
`timescale 1ns/1ns
`default_nettype none
module xbi_top_tb
  import xbi_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_ready, rsp_valid;
  logic [REQ_W-1:0] req_data = '0;
  logic [15:0] rsp_data;
  logic [13:0] addr_out;
  logic [7:0] data_out, data_in;
  logic addr_oe_n, data_oe_n, sel_n, wr_n, rd_dir, ctrl_oe_n, strobe, bit_in;
  logic bus_req_n = 1'b1, slow = 1'b0, grant, ready, fetch, ph3_n, sbit;
  logic [2:0] int_code = 3'h0, int_sync;
  int failures = 0, num_checks = 0, cycles = 0, i, n;

  always #5 sys_clk = ~sys_clk;

  xbi_top dut_u (.SYS_CLK(sys_clk), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_DATA(req_data), .RSP_VALID(rsp_valid),
    .RSP_DATA(rsp_data), .ADDR_OUT(addr_out), .ADDR_OE_N(addr_oe_n),
    .DATA_OUT(data_out), .DATA_IN(data_in), .DATA_OE_N(data_oe_n),
    .MEMORY_SELECT_N(sel_n), .WRITE_N(wr_n), .READ_DIRECTION(rd_dir),
    .CTRL_OE_N(ctrl_oe_n), .BITIO_STROBE(strobe), .BITIO_IN(bit_in),
    .BUS_REQUEST_N(bus_req_n), .BUS_GRANT(grant), .READY(ready),
    .FETCH_INDICATOR(fetch), .PHASE3_REF_N(ph3_n), .INT_CODE(int_code),
    .INT_CODE_SYNC(int_sync));

  xbi_mem_model mem_u (.clk(sys_clk), .slow(slow), .addr(addr_out),
    .wdata(data_out), .sel_n(sel_n), .wr_n(wr_n), .rd_dir(rd_dir),
    .strobe(strobe), .rdata(data_in), .ready(ready), .bit_in(bit_in), .sbit(sbit));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
  begin
    num_checks++;
    if (got !== exp)
      begin
        failures++;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
  end
  endtask

  // offer one request and hold it until req_ready is seen; it is taken at the next rising edge
  task automatic push(input xbi_kind_t k, input logic [12:0] a, input logic [15:0] w);
  begin
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_data  <= {k, a, w};
    n = 0;
    do @(negedge sys_clk); while (req_ready !== 1'b1 && ++n < 200);
    if (req_ready !== 1'b1)
      check(req_ready, 16'h0001);
  end
  endtask

  task automatic idle;
  begin
    @(posedge sys_clk);
    req_valid <= 1'b0;
  end
  endtask

  // read request, then wait for its answer
  task automatic rd(input xbi_kind_t k, input logic [12:0] a, input logic [15:0] e);
  begin
    push(k, a, 16'h0000);
    idle();
    n = 0;
    do @(negedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 400);
    check(rsp_data, e);
  end
  endtask

  // serial output bit seen by the far side
  task automatic bit_out(input xbi_kind_t k, input logic b);
  begin
    push(k, 13'h0155, {15'h0000, b});
    idle();
    n = 0;
    do @(negedge sys_clk); while (strobe !== 1'b1 && ++n < 200);
    @(negedge sys_clk);
    check(sbit, b);
  end
  endtask

  task automatic close_out;
  begin
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  // watchdog
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 30000)
      begin
        failures++;
        close_out();
      end
  end

  initial
  begin
    #15;
    check({sel_n, wr_n, rd_dir, strobe, grant}, 16'h0018);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    // word write, read back, fetch
    push(XBI_K_WRITE, 13'h00A5, 16'hC35A);
    rd(XBI_K_READ, 13'h00A5, 16'hC35A);
    check(mem_u.mem[14'h014A], 16'h00C3);
    rd(XBI_K_FETCH, 13'h00A5, 16'hC35A);
    // wait states
    slow <= 1'b1;
    push(XBI_K_WRITE, 13'h1FFF, 16'h8001);
    rd(XBI_K_READ, 13'h1FFF, 16'h8001);
    slow <= 1'b0;
    // serial bits out and in
    bit_out(XBI_K_BITO, 1'b1);
    bit_out(XBI_K_BITO, 1'b0);
    bit_out(XBI_K_EXTI, 1'b1);
    rd(XBI_K_BITI, 13'h0001, 16'h0001);
    rd(XBI_K_BITI, 13'h0002, 16'h0000);
    // hold: outputs float, buffer fills and refuses
    @(posedge sys_clk);
    bus_req_n <= 1'b0;
    n = 0;
    do @(negedge sys_clk); while (grant !== 1'b1 && ++n < 200);
    check({addr_oe_n, data_oe_n, ctrl_oe_n}, 16'h0007);
    for (i = 0; i < 6; i++)
      begin
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_data  <= {XBI_K_WRITE, 13'h0100 + 13'(i), {4{4'(i)}}};
        @(negedge sys_clk);
        if (req_ready !== 1'b1)
          break;
      end
    check(req_ready, 16'h0000);
    idle();
    bus_req_n <= 1'b1;
    for (int j = 0; j < i; j++)
      rd(XBI_K_READ, 13'h0100 + 13'(j), {4{4'(j)}});
    check(grant, 16'h0000);
    // interrupt code passes the synchroniser
    @(posedge sys_clk);
    int_code <= 3'h5;
    n = 0;
    do @(negedge sys_clk); while (int_sync !== 3'h5 && ++n < 20);
    check(int_sync, 16'h0005);
    close_out();
  end
endmodule
`default_nettype wire
